// file: serial_map.svh
/*
  Register offsets, field positions, reset values and timing constants
  for the asynchronous serial port.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SERIAL_MAP_SVH
`define SERIAL_MAP_SVH

// =====================================================================
// Register word offsets (byte addresses on a 32-bit Wishbone bus)
`define REG_DATA 4'h0
`define REG_STATUS 4'h4
`define REG_CTRL 4'h8
`define REG_BAUD 4'hC

// =====================================================================
// Status bit positions
`define ST_RX_FULL 7
`define ST_ADDR 6
`define ST_TX_FULL 3
`define ST_TX_BUSY 2
`define ST_RX_IRQ 1
`define ST_TX_IRQ 0

// =====================================================================
// Control bit positions
`define CT_IRQ_EN 0
`define CT_SEVEN 1
`define CT_SAMPLE8 2
`define CT_ADDR_EN 3

// =====================================================================
// Reset values and counts
`define CTRL_RESET 8'h00
`define MASK_RESET 8'hFF
`define BAUD_RESET 16'h0000
`define OVS16 5'h10
`define OVS8 5'h08
`define BITS8 4'h8
`define BITS7 4'h7

`endif

// file: serial_pkg.sv
/*
  Types shared by the serial port files.
  Assumes serial_map.svh supplies numeric constants.
*/
package serial_pkg;
  // Receiver states
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_ADDR, RX_STOP} rx_state_t;
  // Transmitter states
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
endpackage : serial_pkg

// file: serial_tick.sv
/*
  Sample clock tick generator: one-cycle pulse every divisor+1 clocks.
  Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "serial_map.svh"

module serial_tick #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Divisor
  input wire logic [WIDTH-1:0] divisor,
  // Sample clock pulse
  output logic tick
);
  // =====================================================================
  // Divider counter
  logic [WIDTH-1:0] count; // Counts down to zero
  logic [WIDTH-1:0] next_count; // Next counter value

  // Reload on zero, else count down
  always_comb begin
    if (count == '0) begin
      next_count = divisor;
    end else begin
      next_count = count - 1'b1;
    end
  end

  // Register counter
  always_ff @(posedge clk) begin
    if (srst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign tick = (count == '0);
endmodule : serial_tick

// file: async_serial.sv
/*
  Asynchronous serial port: double-buffered transmitter, oversampling
  receiver with address bit, two request flip-flops and one shared
  interrupt line, Wishbone classic slave register file.
  Assumes rx_line is already synchronous to clk; one clock domain.
*/
`timescale 1ns/1ps
`include "serial_map.svh"

module async_serial (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial line
  input wire logic rx_line,
  output logic tx_line,
  // Interrupt
  output logic irq
);
  // =====================================================================
  // Bus decode
  logic req; // New access this cycle
  logic wr_data, wr_status, wr_ctrl, wr_baud, rd_data;
  assign req = cyc_i && stb_i && !ack_o;
  assign wr_data = req && we_i && sel_i[0] && adr_i == `REG_DATA;
  assign wr_status = req && we_i && adr_i == `REG_STATUS;
  assign wr_ctrl = req && we_i && sel_i[0] && adr_i == `REG_CTRL;
  assign wr_baud = req && we_i && adr_i == `REG_BAUD;
  assign rd_data = req && !we_i && adr_i == `REG_DATA;

  // =====================================================================
  // Configuration registers
  logic [7:0] ctrl, next_ctrl; // Control bits
  logic [15:0] baud, next_baud; // Sample clock divisor
  logic [7:0] irq_mask, next_irq_mask; // Status interrupt mask bits

  // Byte-lane writes; mask rides in byte 1 of control
  always_comb begin
    next_ctrl = ctrl;
    next_baud = baud;
    next_irq_mask = irq_mask;
    if (wr_ctrl) begin
      next_ctrl = dat_i[7:0];
    end
    if (req && we_i && sel_i[1] && adr_i == `REG_CTRL) begin
      next_irq_mask = dat_i[15:8];
    end
    if (wr_baud) begin
      if (sel_i[0]) begin
        next_baud[7:0] = dat_i[7:0];
      end
      if (sel_i[1]) begin
        next_baud[15:8] = dat_i[15:8];
      end
    end
  end

  // Register configuration
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= `CTRL_RESET;
      baud <= `BAUD_RESET;
      irq_mask <= `MASK_RESET;
    end else begin
      ctrl <= next_ctrl;
      baud <= next_baud;
      irq_mask <= next_irq_mask;
    end
  end

  // =====================================================================
  // Sample clock and baud clock
  logic tick; // Sample clock pulse
  serial_tick #(.WIDTH(16)) u_tick (
    .clk(clk),
    .srst(srst),
    .divisor(baud),
    .tick(tick)
  );

  logic [4:0] ovs; // Samples per bit
  assign ovs = ctrl[`CT_SAMPLE8] ? `OVS8 : `OVS16;
  logic [3:0] nbits; // Data bits per character
  assign nbits = ctrl[`CT_SEVEN] ? `BITS7 : `BITS8;

  // =====================================================================
  // Transmitter: shift register fed from one-deep data register.
  // Frame is start + data + optional address + stop = 9 to 11 bits.
  serial_pkg::tx_state_t tx_state, next_tx_state;
  logic [7:0] tx_hold, next_tx_hold; // Transmit data register
  logic tx_full, next_tx_full; // Data register holds a character
  logic [10:0] tx_shift, next_tx_shift; // Frame bits, LSB first
  logic [3:0] tx_left, next_tx_left; // Bits left in frame
  logic [4:0] tx_sub, next_tx_sub; // Sample ticks within bit
  logic tx_out, next_tx_out; // Line driver
  logic tx_empty_ev; // Data register emptied at start edge
  logic tx_idle_ev; // Transmitter went idle at stop end

  // Build a frame: start low, data, optional address bit, stop high
  // Eleven bits hold the longest frame: 8 data bits plus address bit
  function automatic logic [10:0] frame(input logic [7:0] d, input logic seven, input logic adr);
    if (seven) begin
      frame = adr ? {2'b11, 1'b0, d[6:0], 1'b0} : {3'b111, d[6:0], 1'b0};
    end else begin
      frame = adr ? {1'b1, 1'b0, d, 1'b0} : {2'b11, d, 1'b0};
    end
  endfunction : frame

  // Transmit sequencing
  always_comb begin
    logic load;
    load = 1'b0;
    next_tx_state = tx_state;
    next_tx_hold = tx_hold;
    next_tx_full = tx_full;
    next_tx_shift = tx_shift;
    next_tx_left = tx_left;
    next_tx_sub = tx_sub;
    next_tx_out = tx_out;
    tx_empty_ev = 1'b0;
    tx_idle_ev = 1'b0;
    case (tx_state)
      serial_pkg::TX_IDLE: begin
        next_tx_out = 1'b1;
        if (tick && tx_full) begin
          load = 1'b1;
        end
      end
      serial_pkg::TX_SHIFT: begin
        if (tick) begin
          if (tx_sub == ovs - 5'h01) begin
            next_tx_sub = '0;
            if (tx_left == 4'h1) begin
              // Trailing edge of stop bit
              if (tx_full) begin
                load = 1'b1;
              end else begin
                next_tx_state = serial_pkg::TX_IDLE;
                tx_idle_ev = 1'b1;
                next_tx_out = 1'b1;
              end
            end else begin
              next_tx_left = tx_left - 4'h1;
              next_tx_shift = {1'b1, tx_shift[10:1]};
              next_tx_out = tx_shift[1];
            end
          end else begin
            next_tx_sub = tx_sub + 5'h01;
          end
        end
      end
      default: begin
        next_tx_state = serial_pkg::TX_IDLE;
      end
    endcase
    if (load) begin
      // Start bit leading edge empties the data register
      next_tx_state = serial_pkg::TX_SHIFT;
      next_tx_shift = frame(tx_hold, ctrl[`CT_SEVEN], ctrl[`CT_ADDR_EN]);
      next_tx_left = nbits + 4'h2 + {3'h0, ctrl[`CT_ADDR_EN]};
      next_tx_sub = '0;
      next_tx_out = 1'b0;
      next_tx_full = 1'b0;
      tx_empty_ev = 1'b1;
    end
    if (wr_data) begin
      next_tx_hold = dat_i[7:0];
      next_tx_full = 1'b1;
    end
  end

  // Register transmitter
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_state <= serial_pkg::TX_IDLE;
      tx_hold <= 8'h00;
      tx_full <= 1'b0;
      tx_shift <= 11'h7FF;
      tx_left <= 4'h0;
      tx_sub <= 5'h00;
      tx_out <= 1'b1;
    end else begin
      tx_state <= next_tx_state;
      tx_hold <= next_tx_hold;
      tx_full <= next_tx_full;
      tx_shift <= next_tx_shift;
      tx_left <= next_tx_left;
      tx_sub <= next_tx_sub;
      tx_out <= next_tx_out;
    end
  end
  assign tx_line = tx_out;

  // =====================================================================
  // Receiver: edge search on sample clocks, mid-bit sampling
  serial_pkg::rx_state_t rx_state, next_rx_state;
  logic rx_prev, next_rx_prev; // Line level at previous sample clock
  logic [4:0] rx_sub, next_rx_sub; // Sample ticks within bit
  logic [3:0] rx_cnt, next_rx_cnt; // Data bits received
  logic [7:0] rx_shift, next_rx_shift; // Receive shift register
  logic [7:0] rx_data, next_rx_data; // Receive data register
  logic rx_full, next_rx_full; // Status bit 7
  logic rx_addr, next_rx_addr; // Address bit seen
  logic rx_done; // Character moved to data register
  logic mid; // Sample point of current bit

  assign mid = tick && (rx_sub == ovs - 5'h01);

  // Receive sequencing
  always_comb begin
    next_rx_state = rx_state;
    next_rx_prev = tick ? rx_line : rx_prev;
    next_rx_sub = rx_sub;
    next_rx_cnt = rx_cnt;
    next_rx_shift = rx_shift;
    next_rx_data = rx_data;
    next_rx_full = rx_full;
    next_rx_addr = rx_addr;
    rx_done = 1'b0;
    // Clear first, so an address bit arriving in the same cycle wins
    if (wr_status && sel_i[0] && dat_i[`ST_ADDR]) begin
      next_rx_addr = 1'b0;
    end
    if (tick && rx_state != serial_pkg::RX_IDLE) begin
      next_rx_sub = mid ? 5'h00 : rx_sub + 5'h01;
    end
    case (rx_state)
      serial_pkg::RX_IDLE: begin
        if (tick && rx_prev && !rx_line) begin
          next_rx_state = serial_pkg::RX_START;
          next_rx_sub = {1'b0, ovs[4:1]} + 5'h01; // Half bit to centre
        end
      end
      serial_pkg::RX_START: begin
        if (mid) begin
          // Glitch rejection: a high centre is no start bit
          next_rx_state = rx_line ? serial_pkg::RX_IDLE : serial_pkg::RX_DATA;
          next_rx_cnt = 4'h0;
        end
      end
      serial_pkg::RX_DATA: begin
        if (mid) begin
          next_rx_shift = ctrl[`CT_SEVEN] ? {1'b0, rx_line, rx_shift[6:1]}
                                         : {rx_line, rx_shift[7:1]};
          next_rx_cnt = rx_cnt + 4'h1;
          if (rx_cnt + 4'h1 == nbits) begin
            next_rx_state = serial_pkg::RX_ADDR;
          end
        end
      end
      serial_pkg::RX_ADDR: begin
        if (mid) begin
          if (!rx_line) begin
            next_rx_addr = 1'b1;
            next_rx_state = serial_pkg::RX_STOP;
          end else begin
            rx_done = 1'b1;
            next_rx_state = serial_pkg::RX_IDLE;
          end
        end
      end
      serial_pkg::RX_STOP: begin
        if (mid) begin
          // Low stop is a framing fault; resync anyway
          rx_done = rx_line;
          next_rx_state = serial_pkg::RX_IDLE;
        end
      end
      default: begin
        next_rx_state = serial_pkg::RX_IDLE;
      end
    endcase
    if (rd_data) begin
      next_rx_full = 1'b0;
    end
    if (rx_done) begin
      next_rx_data = rx_shift;
      next_rx_full = 1'b1;
    end
  end

  // Register receiver
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_state <= serial_pkg::RX_IDLE;
      rx_prev <= 1'b1;
      rx_sub <= 5'h00;
      rx_cnt <= 4'h0;
      rx_shift <= 8'h00;
      rx_data <= 8'h00;
      rx_full <= 1'b0;
      rx_addr <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rx_prev <= next_rx_prev;
      rx_sub <= next_rx_sub;
      rx_cnt <= next_rx_cnt;
      rx_shift <= next_rx_shift;
      rx_data <= next_rx_data;
      rx_full <= next_rx_full;
      rx_addr <= next_rx_addr;
    end
  end

  // =====================================================================
  // Request flip-flops: receive set on rising edge of rx_done, transmit on each enabled event pulse
  logic rx_req, next_rx_req; // Receive request
  logic tx_req, next_tx_req; // Transmit request
  logic rx_cond_d; // Delayed receive condition for edge detect

  always_comb begin
    next_rx_req = rx_req;
    next_tx_req = tx_req;
    if (rd_data) begin
      next_rx_req = 1'b0;
    end
    if (wr_data || wr_status) begin
      next_tx_req = 1'b0;
    end
    // Edge of the transfer strobe keeps request and full flag in step
    if (rx_done && !rx_cond_d) begin
      next_rx_req = 1'b1;
    end
    if ((tx_empty_ev || tx_idle_ev) && ctrl[`CT_IRQ_EN]) begin
      next_tx_req = 1'b1;
    end
  end

  // Register requests; set wins over clear
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_req <= 1'b0;
      tx_req <= 1'b0;
      rx_cond_d <= 1'b0;
    end else begin
      rx_req <= next_rx_req;
      tx_req <= next_tx_req;
      rx_cond_d <= rx_done;
    end
  end

  // Uncleared request keeps the line high while its irq_mask bit is set
  assign irq = (rx_req && irq_mask[`ST_RX_IRQ]) || (tx_req && irq_mask[`ST_TX_IRQ]);

  // =====================================================================
  // Read mux and ack
  logic [7:0] status; // Status register image
  always_comb begin
    status = 8'h00;
    status[`ST_RX_FULL] = rx_full;
    status[`ST_ADDR] = rx_addr;
    status[`ST_TX_FULL] = tx_full;
    status[`ST_TX_BUSY] = tx_state != serial_pkg::TX_IDLE;
    status[`ST_RX_IRQ] = rx_req;
    status[`ST_TX_IRQ] = tx_req;
  end

  logic [31:0] next_dat_o; // Read data
  logic next_ack; // Ack, one cycle per request
  always_comb begin
    next_ack = req;
    next_dat_o = 32'h0000_0000;
    if (req && !we_i) begin
      case (adr_i)
        `REG_DATA: next_dat_o = {24'h0, rx_data};
        `REG_STATUS: next_dat_o = {24'h0, status};
        `REG_CTRL: next_dat_o = {16'h0, irq_mask, ctrl};
        `REG_BAUD: next_dat_o = {16'h0, baud};
        default: next_dat_o = 32'h0000_0000;
      endcase
    end
  end

  // Register bus outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= next_ack;
      dat_o <= next_dat_o;
    end
  end
endmodule : async_serial

// file: async_serial_irq_timing_properties.sv
/*
  Port-level checker for the serial port: bus answer, refusal, framing.
  Assumes one clock and baud divisor 0 or more.
*/
`timescale 1ns/1ps
module async_serial_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Line and interrupt
  input wire logic rx_line,
  input wire logic tx_line,
  input wire logic irq
);
  // =====================================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  property p_ack_once; ack_o |=> !ack_o; endproperty
  property p_ack_idle; !stb_i |=> !ack_o; endproperty
  // Shortest start bit is 8 clocks (8x sampling, divisor 0)
  property p_start_len; $fell(tx_line) |-> !tx_line [*8]; endproperty
  property p_unmapped; ack_o && !we_i && adr_i[1:0] != 2'h0 |-> dat_o == 32'h0; endproperty
  // Full flag and receive request move together
  property p_rx_pair; ack_o && !we_i && adr_i == 4'h4 |-> dat_o[7] == dat_o[1]; endproperty
  sequence s_data_rd; ack_o && !we_i && adr_i == 4'h0; endsequence
  property p_rx_clear;
    s_data_rd ##[2:4] (ack_o && !we_i && adr_i == 4'h4) |-> !dat_o[7];
  endproperty
  property p_reset_quiet; $fell(srst) |-> tx_line && !irq && !ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no answer");
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
  a_start_len: assert property (p_start_len) else $error("short start bit");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_rx_pair: assert property (p_rx_pair) else $error("flag and request differ");
  a_rx_clear: assert property (p_rx_clear) else $error("read kept full flag");
  a_reset_quiet: assert property (p_reset_quiet) else $error("bad reset state");
  c_rx: cover property (s_data_rd);
  c_tx: cover property ($fell(tx_line));
  c_bad: cover property (ack_o && adr_i[1:0] != 2'h0);
endmodule : async_serial_checker

bind async_serial async_serial_checker u_chk (.clk(clk), .srst(srst), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .rx_line(rx_line), .tx_line(tx_line), .irq(irq));

// file: serial_peer.sv
/*
  Remote serial device: decodes the port's output, sends frames to it.
  Assumes tasks are entered just after a rising clock edge.
*/
`timescale 1ns/1ps
module serial_peer (
  // Clock
  input wire logic clk,
  // Lines
  input wire logic tx_line,
  output logic rx_line
);
  logic [7:0] got [$]; // Decoded bytes
  time starts [$]; // Start edge times
  int bit_clks = 16; // Clocks per bit on the port output
  initial rx_line = 1'b1;
  // =====================================================================
  // Decoder: sample mid-bit, LSB first; returns in the stop bit, or in the address bit when there is one
  always @(negedge tx_line) begin
    logic [7:0] b;
    starts.push_back($time);
    repeat (bit_clks + bit_clks / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = tx_line;
      repeat (bit_clks) @(posedge clk);
    end
    got.push_back(b);
  end
  // =====================================================================
  // Sender: start low, data LSB first, optional low address bit, stop
  task automatic send(input logic [7:0] v, input int nbits, input bit adr, input int bclk,
                      input int stop);
    rx_line <= 1'b0;
    repeat (bclk) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      rx_line <= v[i];
      repeat (bclk) @(posedge clk);
    end
    if (adr) begin
      rx_line <= 1'b0;
      repeat (bclk) @(posedge clk);
    end
    // Stop may be cut short to probe early rescan
    rx_line <= 1'b1;
    repeat (stop) @(posedge clk);
  endtask : send
endmodule : serial_peer

// file: test_async_serial_irq_timing.sv
/*
  Self-checking bench for the serial port.
  Assumes the peer model and the bound checker.
*/
`timescale 1ns/1ps
module test_async_serial_irq_timing;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic rx_line;
  logic tx_line;
  logic irq;
  int n_fail = 0;
  int checks = 0;
  logic [31:0] q;
  always #5 clk = ~clk;
  async_serial DUT (.clk(clk), .srst(srst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .rx_line(rx_line), .tx_line(tx_line), .irq(irq));
  serial_peer peer (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));
  // =====================================================================
  // Bus and compare tasks
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // Classic cycle: hold until ack is sampled, then idle one cycle
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    cmp(r, e);
  endtask : rdc
  // =====================================================================
  // Scenarios
  task automatic t_regs;
    rdc(4'h8, 32'h0000FF00);
    rdc(4'h4, 32'h00000000);
    rdc(4'hC, 32'h00000000);
    wr(4'h2, 32'h000000FF); // Misaligned write is ignored
    rdc(4'h2, 32'h00000000);
    rdc(4'h8, 32'h0000FF00);
    $display("done t_regs");
  endtask : t_regs
  // Two characters back to back, then idle request
  task automatic t_tx;
    wr(4'h8, 32'h0000FF01);
    wr(4'h0, 32'h000000A5);
    repeat (40) @(posedge clk);
    wr(4'h0, 32'h0000003C);
    repeat (150) @(posedge clk);
    // Clear the start-edge request while busy; idle must set it again
    wr(4'h4, 32'h00000000);
    rdc(4'h4, 32'h00000004);
    repeat (250) @(posedge clk);
    cmp(peer.got.size(), 2);
    cmp(peer.got[0], 8'hA5);
    cmp(peer.got[1], 8'h3C);
    cmp(32'(peer.starts[1] - peer.starts[0]), 1600);
    rdc(4'h4, 32'h00000001);
    cmp(32'(irq), 32'h1);
    wr(4'h4, 32'h00000000);
    rdc(4'h4, 32'h00000000);
    cmp(32'(irq), 32'h0);
    $display("done t_tx");
  endtask : t_tx
  task automatic t_tx_off;
    wr(4'h8, 32'h0000FF00);
    wr(4'h0, 32'h00000081);
    repeat (250) @(posedge clk);
    cmp(peer.got[2], 8'h81);
    rdc(4'h4, 32'h00000000);
    $display("done t_tx_off");
  endtask : t_tx_off
  // Eight bits plus address bit: start leaves one clock after the write
  task automatic t_tx_addr;
    wr(4'h8, 32'h0000FF08);
    wr(4'h0, 32'h0000005A);
    repeat (151) @(posedge clk);
    cmp(32'(tx_line), 32'h0);
    repeat (16) @(posedge clk);
    cmp(32'(tx_line), 32'h1);
    repeat (20) @(posedge clk);
    cmp(peer.got[3], 8'h5A);
    $display("done t_tx_addr");
  endtask : t_tx_addr
  // Receive at 8x, mask toggles the shared line
  task automatic t_rx;
    logic a;
    wr(4'h8, 32'h0000FF04);
    peer.send(8'h96, 8, 1'b0, 8, 8);
    repeat (10) @(posedge clk);
    rdc(4'h4, 32'h00000082);
    wr(4'h8, 32'h00000004);
    a = irq;
    wr(4'h8, 32'h0000FF04);
    cmp(32'(a ^ irq), 32'h1);
    rdc(4'h0, 32'h00000096);
    rdc(4'h4, 32'h00000000);
    $display("done t_rx");
  endtask : t_rx
  // Address bit, short stop, next frame at 16x
  task automatic t_rx_addr;
    wr(4'h8, 32'h0000FF02);
    peer.send(8'h2A, 7, 1'b1, 16, 10);
    peer.send(8'h55, 7, 1'b0, 16, 16);
    repeat (10) @(posedge clk);
    rdc(4'h4, 32'h000000C2);
    rdc(4'h0, 32'h00000055);
    wr(4'h4, 32'h00000040);
    rdc(4'h4, 32'h00000000);
    $display("done t_rx_addr");
  endtask : t_rx_addr
  // =====================================================================
  // Verdict
  task automatic stop_test;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_tx();
    t_tx_off();
    t_tx_addr();
    t_rx();
    t_rx_addr();
    stop_test();
  end
endmodule : test_async_serial_irq_timing
